// *** hdl/spc_top.sv ***
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module spc_top #(
	parameter int unsigned MS_CYCLES = spc_pkg::MS_CYCLES
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              ce,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output spc_pkg::spc_drv_s      drv_pins,
	output logic                   enable_pwm_out,
	output logic      [3:0]        bridge_pwm_out,
	output logic      [11:0]       dac_ab_code,
	output logic      [11:0]       dac_cd_code,
	output logic                   motion_pulse_out
);

	// Moves a rate one increment toward a goal without passing it.
	// A zero increment means no ramp at all, so the goal is taken at once
	// rather than leaving the sequencer stuck short of it.
	function automatic logic [15:0] ramp(input logic [15:0] cur,
		input logic [15:0] goal, input logic [7:0] inc);
		logic [15:0] g;
		logic [16:0] up;
		g  = (goal < spc_pkg::MIN_PPS) ? spc_pkg::MIN_PPS : goal;
		up = {1'b0, cur} + {9'h000, inc};
		if (inc == 8'h00)
			ramp = g;
		else if (cur < g)
			ramp = (up > {1'b0, g}) ? g : up[15:0];
		else if ((cur - g) <= {8'h00, inc})
			ramp = g;
		else
			ramp = cur - {8'h00, inc};
	endfunction

	// Bus bookkeeping registers.
	logic                   wr_pend_reg;  // A write data phase is in progress.
	logic [7:0]             wr_addr_reg;  // Byte offset captured in the address phase.
	logic [31:0]            hrdata_reg;   // Read data, latched at the address phase.

	// Software-visible configuration.
	spc_pkg::spc_drv_s      ctrl_reg;     // Driver control pin levels.
	logic [31:0]            bridge_reg;   // Four bridge input duty values.
	logic [7:0]             enpwm_reg;    // Enable-line duty value.
	logic [11:0]            dac_ab_reg;   // Reference code for bridge A/B.
	logic [11:0]            dac_cd_reg;   // Reference code for bridge C/D.
	logic [7:0]             inc_reg;      // Rate increment per update.
	logic [7:0]             tb_reg;       // Milliseconds between updates.
	logic [15:0]            target_reg;   // Programmed pulse rate.
	logic [15:0]            steps_reg;    // Programmed counted-move length.

	// PWM generation.
	logic [4:0]             pre_reg;      // Prescaler toward one PWM slot.
	logic [7:0]             phase_reg;    // Position within the PWM period.
	logic                   enpwm_o_reg;  // Enable-line PWM output flop.
	logic [3:0]             bridge_o_reg; // Bridge PWM output flops.

	// Motion sequencer.
	spc_pkg::spc_state_e    state_reg;
	spc_pkg::spc_state_e    state_next;
	logic [15:0]            rate_reg;     // Present pulse rate.
	logic [15:0]            rate_next;
	logic [15:0]            tgt_reg;      // Rate the ramp is heading for.
	logic [15:0]            tgt_next;
	logic [15:0]            left_reg;     // Pulses still owed in a counted move.
	logic [15:0]            left_next;
	logic [26:0]            acc_reg;      // Phase accumulator for pulse timing.
	logic [26:0]            acc_next;
	logic                   step_reg;     // Pulse output flop.
	logic                   step_next;
	logic [8:0]             hold_reg;     // High-time counter for a single pulse.
	logic [8:0]             hold_next;
	logic [23:0]            ms_reg;       // Cycles within the present millisecond.
	logic [7:0]             ivl_reg;      // Milliseconds since the last update.

	// Address phase decode.
	wire addr_ok  = hsel & hready & htrans[1];
	wire word_wr  = addr_ok & hwrite & (hsize == 3'b010);

	// Data phase write strobes; writes land at the end of the data phase.
	wire wr_ctrl   = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_CTRL);
	wire wr_bridge = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_BRIDGE);
	wire wr_enpwm  = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_ENPWM);
	wire wr_dac    = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_DAC);
	wire wr_ramp   = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_RAMP);
	wire wr_target = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_TARGET);
	wire wr_steps  = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_STEPS);
	wire wr_cmd    = wr_pend_reg & (wr_addr_reg == spc_pkg::OFF_CMD);

	// One-cycle command pulses taken from a command register write.
	wire cmd_ss     = wr_cmd & hwdata[spc_pkg::CMD_START_STOP];
	wire cmd_update = wr_cmd & hwdata[spc_pkg::CMD_UPDATE];
	wire cmd_single = wr_cmd & hwdata[spc_pkg::CMD_SINGLE];
	wire cmd_move   = wr_cmd & hwdata[spc_pkg::CMD_MOVE];

	// Read selection; unmapped offsets read as zero.
	wire [7:0]  ra = haddr[7:0];
	wire [31:0] rd_mux =
		(ra == spc_pkg::OFF_CTRL)   ? {24'h000000, ctrl_reg} :
		(ra == spc_pkg::OFF_BRIDGE) ? bridge_reg :
		(ra == spc_pkg::OFF_ENPWM)  ? {24'h000000, enpwm_reg} :
		(ra == spc_pkg::OFF_DAC)    ? {4'h0, dac_cd_reg, 4'h0, dac_ab_reg} :
		(ra == spc_pkg::OFF_RAMP)   ? {16'h0000, tb_reg, inc_reg} :
		(ra == spc_pkg::OFF_TARGET) ? {16'h0000, target_reg} :
		(ra == spc_pkg::OFF_STEPS)  ? {16'h0000, steps_reg} :
		(ra == spc_pkg::OFF_STATUS) ? {11'h000, state_reg, rate_reg} :
		32'h00000000;

	// The driver must be awake, out of reset and enabled for a command to start pulses from idle.
	wire drv_ready = ~ctrl_reg.enable_n & ctrl_reg.sleep_control
		& ctrl_reg.driver_reset_control;

	// PWM slot strobe and end of period.
	wire pre_end   = (pre_reg == 5'(spc_pkg::PWM_PRE_CYCLES - 1));
	wire phase_end = (phase_reg == 8'(spc_pkg::PWM_STEPS - 1));

	// Millisecond tick and rate update strobe.
	wire ms_tick = (ms_reg == 24'(MS_CYCLES - 1));
	wire upd     = ms_tick & (({1'b0, ivl_reg} + 9'h001) >= {1'b0, tb_reg});

	// Pulse timing: the output toggles on each wrap, so rising edges occur
	// at the programmed rate per second.
	wire [27:0] acc_sum = {1'b0, acc_reg} + {11'h000, rate_reg, 1'b0};
	wire        wrap    = acc_sum >= 28'(spc_pkg::CLK_HZ);
	wire [26:0] acc_adv = wrap ? 27'(acc_sum - 28'(spc_pkg::CLK_HZ)) : acc_sum[26:0];

	// Bus slave: zero wait states, always OKAY; the answer flags are constant flops.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata_reg  <= 32'h00000000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
		else if (ce)
		begin
			wr_pend_reg <= word_wr;
			wr_addr_reg <= haddr[7:0];
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			if (addr_ok & ~hwrite)
				hrdata_reg <= rd_mux;
		end
	end

	// Configuration registers; each pin bit maps straight to its output.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg   <= spc_pkg::spc_drv_s'(spc_pkg::CTRL_RST);
			bridge_reg <= 32'h00000000;
			enpwm_reg  <= 8'h00;
			dac_ab_reg <= 12'h000;
			dac_cd_reg <= 12'h000;
			inc_reg    <= 8'h00;
			tb_reg     <= 8'h00;
			target_reg <= spc_pkg::TARGET_RST;
			steps_reg  <= 16'h0000;
		end
		else if (ce)
		begin
			// Falloff select is one flop bit, so it can only be high or low.
			if (wr_ctrl)
				ctrl_reg <= spc_pkg::spc_drv_s'(hwdata[7:0]);
			if (wr_bridge)
				bridge_reg <= hwdata;
			if (wr_enpwm)
				enpwm_reg <= hwdata[7:0];
			if (wr_dac)
			begin
				dac_ab_reg <= hwdata[11:0];
				dac_cd_reg <= hwdata[27:16];
			end
			if (wr_ramp)
			begin
				inc_reg <= hwdata[7:0];
				tb_reg  <= hwdata[15:8];
			end
			if (wr_target)
				target_reg <= hwdata[15:0];
			if (wr_steps)
				steps_reg <= hwdata[15:0];
		end
	end

	// PWM: 255 slots per period, high while the slot is below the duty,
	// so duty 0 never goes high and duty 255 never goes low. The millisecond
	// time base shares this block; its interval count restarts at each update.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pre_reg      <= 5'h00;
			phase_reg    <= 8'h00;
			enpwm_o_reg  <= 1'b0;
			bridge_o_reg <= 4'h0;
			ms_reg       <= 24'h000000;
			ivl_reg      <= 8'h00;
		end
		else if (ce)
		begin
			pre_reg <= pre_end ? 5'h00 : pre_reg + 5'h01;
			if (pre_end)
				phase_reg <= phase_end ? 8'h00 : phase_reg + 8'h01;
			enpwm_o_reg <= phase_reg < enpwm_reg;
			for (int i = 0; i < 4; i++)
				bridge_o_reg[i] <= phase_reg < bridge_reg[8 * i +: 8];
			ms_reg <= ms_tick ? 24'h000000 : ms_reg + 24'h000001;
			if (upd)
				ivl_reg <= 8'h00;
			else if (ms_tick && ivl_reg != 8'hFF)
				ivl_reg <= ivl_reg + 8'h01;
		end
	end

	// Motion sequencer next-state logic.
	always_comb
	begin
		state_next = state_reg;
		rate_next  = rate_reg;
		tgt_next   = tgt_reg;
		left_next  = left_reg;
		acc_next   = acc_adv;
		step_next  = wrap ? ~step_reg : step_reg;
		hold_next  = hold_reg;
		case (state_reg)
			spc_pkg::ST_IDLE:
			begin
				acc_next  = 27'h0000000;
				step_next = 1'b0;
				hold_next = 9'h000;
				if (drv_ready && cmd_ss)
				begin
					state_next = spc_pkg::ST_RUN;
					rate_next  = spc_pkg::MIN_PPS;
					tgt_next   = target_reg;
				end
				else if (drv_ready && cmd_single)
				begin
					state_next = spc_pkg::ST_SINGLE;
					step_next  = 1'b1;
				end
				else if (drv_ready && cmd_move && steps_reg != 16'h0000)
				begin
					state_next = spc_pkg::ST_MOVE;
					rate_next  = target_reg;
					left_next  = steps_reg;
				end
			end
			spc_pkg::ST_RUN:
			begin
				if (cmd_ss)
					state_next = spc_pkg::ST_STOP;
				if (cmd_update)
					tgt_next = target_reg;
				// Once at the target the ramp returns it unchanged.
				if (upd)
					rate_next = ramp(rate_reg, tgt_reg, inc_reg);
			end
			spc_pkg::ST_STOP:
			begin
				if (upd)
					rate_next = ramp(rate_reg, spc_pkg::MIN_PPS, inc_reg);
				// Stop only with the output low, so the last pulse is whole.
				if (rate_reg == spc_pkg::MIN_PPS && !step_reg)
				begin
					state_next = spc_pkg::ST_IDLE;
					step_next  = 1'b0;
				end
			end
			spc_pkg::ST_MOVE:
			begin
				// Each rising edge is one step owed less.
				if (wrap && !step_reg)
					left_next = left_reg - 16'h0001;
				if (cmd_ss || (wrap && step_reg && left_reg == 16'h0000))
				begin
					state_next = spc_pkg::ST_IDLE;
					step_next  = 1'b0;
				end
			end
			spc_pkg::ST_SINGLE:
			begin
				acc_next  = 27'h0000000;
				step_next = 1'b1;
				hold_next = hold_reg + 9'h001;
				if (hold_reg == 9'(spc_pkg::STEP_HIGH_CYCLES - 1))
				begin
					state_next = spc_pkg::ST_IDLE;
					step_next  = 1'b0;
				end
			end
			default:
			begin
				state_next = spc_pkg::ST_IDLE;
				step_next  = 1'b0;
			end
		endcase
	end

	// Motion sequencer registers.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= spc_pkg::ST_IDLE;
			rate_reg  <= spc_pkg::MIN_PPS;
			tgt_reg   <= spc_pkg::MIN_PPS;
			left_reg  <= 16'h0000;
			acc_reg   <= 27'h0000000;
			step_reg  <= 1'b0;
			hold_reg  <= 9'h000;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			rate_reg  <= rate_next;
			tgt_reg   <= tgt_next;
			left_reg  <= left_next;
			acc_reg   <= acc_next;
			step_reg  <= step_next;
			hold_reg  <= hold_next;
		end
	end

	// Outputs straight from their flops.
	assign hrdata           = hrdata_reg;
	assign drv_pins         = ctrl_reg;
	assign enable_pwm_out   = enpwm_o_reg;
	assign bridge_pwm_out   = bridge_o_reg;
	assign dac_ab_code      = dac_ab_reg;
	assign dac_cd_code      = dac_cd_reg;
	assign motion_pulse_out = step_reg;

endmodule

// *** shared/spc_pkg.sv ***
// Shared constants and types for the stepper pulse and PWM controller.
package spc_pkg;

	// System clock and the time constants derived from it.
	localparam int unsigned CLK_HZ           = 125_000_000;
	localparam int unsigned CLK_PERIOD_NS    = 8;
	localparam int unsigned PWM_FREQ_HZ      = 31_250;
	localparam int unsigned PWM_STEPS        = 255;
	// Prescaler rounded to the nearest whole cycle, so the rate is close to the target.
	localparam int unsigned PWM_PRE_CYCLES   =
		(CLK_HZ + (PWM_FREQ_HZ * PWM_STEPS) / 2) / (PWM_FREQ_HZ * PWM_STEPS);
	localparam int unsigned MS_PERIOD_NS     = 1_000_000;
	localparam int unsigned MS_CYCLES        = MS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned STEP_HIGH_NS     = 2_000;
	localparam int unsigned STEP_HIGH_CYCLES =
		(STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Slowest stepping rate in pulses per second; a run starts here and a stop ramps back down to it.
	localparam logic [15:0] MIN_PPS = 16'h003E;

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BRIDGE = 8'h04;
	localparam logic [7:0] OFF_ENPWM  = 8'h08;
	localparam logic [7:0] OFF_DAC    = 8'h0C;
	localparam logic [7:0] OFF_RAMP   = 8'h10;
	localparam logic [7:0] OFF_TARGET = 8'h14;
	localparam logic [7:0] OFF_STEPS  = 8'h18;
	localparam logic [7:0] OFF_CMD    = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// Command register bit positions.
	localparam int unsigned CMD_START_STOP = 0;
	localparam int unsigned CMD_UPDATE     = 1;
	localparam int unsigned CMD_SINGLE     = 2;
	localparam int unsigned CMD_MOVE       = 3;

	// Values after reset.
	localparam logic [7:0]  CTRL_RST   = 8'h20;
	localparam logic [15:0] TARGET_RST = 16'h003E;

	// Driver control pins, packed as they sit in the control register.
	typedef struct packed {
		logic       sleep_control;
		logic       driver_reset_control;
		logic       enable_n;
		logic       rotation_direction;
		logic [2:0] microstep_select;
		logic       current_falloff_select;
	} spc_drv_s;

	// Motion sequencer states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_RUN    = 5'h02,
		ST_STOP   = 5'h04,
		ST_MOVE   = 5'h08,
		ST_SINGLE = 5'h10
	} spc_state_e;

endpackage

// *** tb/spc_assertions.sv ***
`timescale 1ns/1ps
// Checks the motor pins against the bus writes that set them.
module spc_checker #(
	parameter int unsigned MS_CYCLES = 20
) (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              ce,
	input wire logic              hsel,
	input wire logic [31:0]       haddr,
	input wire logic [1:0]        htrans,
	input wire logic              hwrite,
	input wire logic [2:0]        hsize,
	input wire logic [31:0]       hwdata,
	input wire logic              hready,
	input wire logic [31:0]       hrdata,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire spc_pkg::spc_drv_s drv_pins,
	input wire logic              enable_pwm_out,
	input wire logic [3:0]        bridge_pwm_out,
	input wire logic [11:0]       dac_ab_code,
	input wire logic [11:0]       dac_cd_code,
	input wire logic              motion_pulse_out
);
	logic       wv_reg;       // A word write is in its data phase.
	logic [7:0] wa_reg;       // Offset of that write.
	logic [7:0] en_duty_reg;  // Shadow of the enable-line duty.
	logic [7:0] br3_duty_reg; // Shadow of bridge input 3 duty.
	logic       cmd_reg;      // Some motion command has been written.
	wire take_w = ce && hsel && hready && htrans[1] && hwrite && hsize == 3'b010;
	wire wr_ctrl = wv_reg && wa_reg == spc_pkg::OFF_CTRL;
	wire wr_dac = wv_reg && wa_reg == spc_pkg::OFF_DAC;
	wire wr_en = wv_reg && wa_reg == spc_pkg::OFF_ENPWM;
	wire wr_br = wv_reg && wa_reg == spc_pkg::OFF_BRIDGE;
	wire wr_cmd = wv_reg && wa_reg == spc_pkg::OFF_CMD && hwdata[3:0] != 4'h0;
	// Shadows follow the bus, so the checks need no view of the body.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wv_reg <= 1'b0;
			wa_reg <= 8'h00;
			en_duty_reg <= 8'h00;
			br3_duty_reg <= 8'h00;
			cmd_reg <= 1'b0;
		end
		else
		begin
			wv_reg <= take_w;
			wa_reg <= haddr[7:0];
			en_duty_reg <= wr_en ? hwdata[7:0] : en_duty_reg;
			br3_duty_reg <= wr_br ? hwdata[31:24] : br3_duty_reg;
			cmd_reg <= cmd_reg || wr_cmd;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_ctrl_follow;
		wr_ctrl |=> drv_pins == $past(hwdata[7:0]);
	endproperty
	property p_ctrl_hold;
		!$stable(drv_pins) |-> $past(wr_ctrl);
	endproperty
	property p_dac;
		wr_dac |=> dac_ab_code == $past(hwdata[11:0]) && dac_cd_code == $past(hwdata[27:16]);
	endproperty
	property p_en_full;
		(en_duty_reg == 8'hFF)[*3] |-> enable_pwm_out;
	endproperty
	property p_en_zero;
		(en_duty_reg == 8'h00)[*3] |-> !enable_pwm_out;
	endproperty
	property p_br_full;
		(br3_duty_reg == 8'hFF)[*3] |-> bridge_pwm_out[3];
	endproperty
	property p_no_cmd;
		!cmd_reg |-> !motion_pulse_out;
	endproperty
	property p_step_ready;
		$rose(motion_pulse_out) |-> !drv_pins.enable_n && drv_pins.sleep_control
			&& drv_pins.driver_reset_control;
	endproperty
	a_ctrl_follow: assert property (p_ctrl_follow)
		else $error("control pins differ from written bits");
	a_ctrl_hold: assert property (p_ctrl_hold)
		else $error("control pins moved without a write");
	a_dac: assert property (p_dac)
		else $error("reference codes differ from written value");
	a_en_full: assert property (p_en_full)
		else $error("full duty enable line went low");
	a_en_zero: assert property (p_en_zero)
		else $error("zero duty enable line went high");
	a_br_full: assert property (p_br_full)
		else $error("full duty bridge line went low");
	a_no_cmd: assert property (p_no_cmd)
		else $error("step output rose with no command");
	a_step_ready: assert property (p_step_ready)
		else $error("step issued while driver not ready");
	c_step: cover property ($rose(motion_pulse_out));
	c_ctrl: cover property (wr_ctrl);
	c_en_full: cover property (en_duty_reg == 8'hFF && enable_pwm_out);
endmodule

// *** tb/spc_drv_model.sv ***
`timescale 1ns/1ps
// Behavioural driver: counts the steps the motor would take.
module spc_drv_model (
	input  wire logic              hclk,
	input  wire spc_pkg::spc_drv_s drv_pins,
	input  wire logic              step_in,
	output int                     steps
);
	logic step_q = 1'b0; // Step line level at the last edge.
	// A held reset pin clears the count; steps need the driver awake and enabled.
	always @(posedge hclk)
	begin
		step_q <= step_in;
		if (!drv_pins.driver_reset_control)
			steps <= 0;
		else if (step_in && !step_q && drv_pins.sleep_control && !drv_pins.enable_n)
			steps <= steps + 1;
	end
endmodule

// *** tb/spc_tb_top.sv ***
`timescale 1ns/1ps
// Drives the register bus and checks the motor pins and status.
module stepper_pulse_pwm_controller_tb_top;
	localparam int unsigned MS = 20; // Short millisecond keeps ramps brief.
	logic              hclk;
	logic              hresetn;
	logic              ce;
	logic              hsel;
	logic [31:0]       haddr;
	logic [1:0]        htrans;
	logic              hwrite;
	logic [2:0]        hsize;
	logic [31:0]       hwdata;
	logic [31:0]       hrdata;
	logic              hreadyout;
	logic              hresp;
	spc_pkg::spc_drv_s drv_pins;
	logic              enable_pwm_out;
	logic [3:0]        bridge_pwm_out;
	logic [11:0]       dac_ab_code;
	logic [11:0]       dac_cd_code;
	logic              motion_pulse_out;
	int                steps;
	int                error_cnt;
	int                comparisons;
	int                cyc;
	int                s0;
	int                cnt [5];
	logic [31:0]       rd;
	spc_top #(.MS_CYCLES(MS)) dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.drv_pins(drv_pins), .enable_pwm_out(enable_pwm_out), .bridge_pwm_out(bridge_pwm_out),
		.dac_ab_code(dac_ab_code), .dac_cd_code(dac_cd_code),
		.motion_pulse_out(motion_pulse_out));
	spc_drv_model mdl (.hclk(hclk), .drv_pins(drv_pins), .step_in(motion_pulse_out),
		.steps(steps));
	// One single word transfer; read data lands in rd.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// A hang past the expected run length ends the run as a failure.
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 80000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{error_cnt, comparisons, cyc} = '0;
		ce = 1'b1;
		hsize = 3'b010;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		chk({24'h0, drv_pins}, 32'h20);
		bus(0, spc_pkg::OFF_CTRL, 0);
		chk(rd, 32'h20);
		bus(0, spc_pkg::OFF_TARGET, 0);
		chk(rd, 32'h3E);
		bus(0, 8'h24, 0);
		chk(rd, 32'h0);
		chk({30'h0, hreadyout, hresp}, 32'h2);
		foreach (cnt[i])
		begin
			bus(1, spc_pkg::OFF_CTRL, 32'hC1 - i % 2);
			chk({24'h0, drv_pins}, 32'hC1 - i % 2);
		end
		bus(1, spc_pkg::OFF_DAC, 32'h0ABC0FFF);
		chk({20'h0, dac_ab_code}, 32'hFFF);
		chk({20'h0, dac_cd_code}, 32'hABC);
		$display("pins and references done");
		bus(1, spc_pkg::OFF_BRIDGE, 32'hFF804000);
		bus(1, spc_pkg::OFF_ENPWM, 32'h01);
		repeat (20) @(posedge hclk);
		cnt = '{default: 0};
		repeat (4080)
		begin
			@(posedge hclk);
			for (int i = 0; i < 4; i++)
				cnt[i] += int'(bridge_pwm_out[i] === 1'b1);
			cnt[4] += int'(enable_pwm_out === 1'b1);
		end
		chk(cnt[0], 0);
		chk(cnt[1], 1024);
		chk(cnt[2], 2048);
		chk(cnt[3], 4080);
		chk(cnt[4], 16);
		bus(1, spc_pkg::OFF_ENPWM, 32'hFF);
		repeat (8) @(posedge hclk);
		chk({31'h0, enable_pwm_out}, 32'h1);
		// With the clock enable low the bus must be frozen, so this write is lost.
		@(posedge hclk);
		ce <= 1'b0;
		bus(1, spc_pkg::OFF_ENPWM, 32'h00);
		@(posedge hclk);
		ce <= 1'b1;
		bus(0, spc_pkg::OFF_ENPWM, 0);
		chk(rd, 32'hFF);
		$display("pwm done");
		s0 = steps;
		bus(1, spc_pkg::OFF_CMD, 32'h4);
		repeat (500) @(posedge hclk);
		chk(steps - s0, 1);
		bus(1, spc_pkg::OFF_TARGET, 32'hF424);
		bus(1, spc_pkg::OFF_STEPS, 32'h5);
		s0 = steps;
		bus(1, spc_pkg::OFF_CMD, 32'h8);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[15:0], 32'hF424);
		repeat (11000) @(posedge hclk);
		chk(steps - s0, 5);
		bus(1, spc_pkg::OFF_CMD, 32'h2);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[20:16], 32'h1);
		$display("single and counted done");
		bus(1, spc_pkg::OFF_RAMP, 32'h64FF);
		bus(1, spc_pkg::OFF_TARGET, 32'h043A);
		bus(1, spc_pkg::OFF_CMD, 32'h1);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[20:0], 32'h2003E);
		repeat (3000) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[15:0], 32'h013D);
		repeat (8000) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[15:0], 32'h043A);
		bus(1, spc_pkg::OFF_TARGET, 32'h0638);
		repeat (2100) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[15:0], 32'h043A);
		bus(1, spc_pkg::OFF_CMD, 32'h2);
		repeat (5000) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[15:0], 32'h0638);
		bus(1, spc_pkg::OFF_CMD, 32'h1);
		repeat (3000) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[20:0], 32'h40539);
		repeat (11000) @(posedge hclk);
		bus(0, spc_pkg::OFF_STATUS, 0);
		chk(rd[20:0], 32'h1003E);
		$display("continuous stepping done");
		tally_and_finish();
	end
endmodule
bind spc_top spc_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.drv_pins(drv_pins), .enable_pwm_out(enable_pwm_out), .bridge_pwm_out(bridge_pwm_out),
	.dac_ab_code(dac_ab_code), .dac_cd_code(dac_cd_code), .motion_pulse_out(motion_pulse_out));
